// ==== core/sps_device.sv ====
// Chosen here: the register addresses and the strobed register port.
`include "sps_params.svh"

module sps_device (
  // Serial link to the bus master
  sps_if.device link,
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Static configuration from the management side
  input wire logic cpol,
  input wire logic cpha,
  input wire logic bit_order_swap,
  input wire logic serial_port_disable,
  // Address straps
  input wire logic [3:0] rxd_hi,
  input wire logic rx_er,
  // Latched status events
  input wire logic [`SPS_DATA_W-1:0] status_set,
  // Write notification and captured address
  output logic wr_strobe_q,
  output logic [`SPS_ADDR_W-1:0] wr_addr_q,
  output logic [`SPS_DATA_W-1:0] wr_data_q,
  output logic [4:0] mgmt_port_address_q
);

  logic [2:0] link_s;
  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic lead;
  logic trail;
  logic sample_edge;
  logic shift_edge;
  logic cs_fall;
  sps_pkg::sps_dev_state_type state_q;
  logic [4:0] cnt_q;
  logic [6:0] cmd_sh_q;
  logic [`SPS_DATA_W-1:0] rx_sh_q;
  logic [`SPS_DATA_W-1:0] tx_sh_q;
  logic [`SPS_DATA_W-1:0] status_q;
  logic [`SPS_DATA_W-1:0] match_q;
  logic [`SPS_ADDR_W-1:0] addr_q;
  logic burst_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic [4:0] strap_meta_q;
  logic [`SPS_DATA_W-1:0] regs_q [0:`SPS_NUM_REGS-1];
  logic [7:0] cmd_byte;
  logic [`SPS_ADDR_W-1:0] cmd_addr;
  logic [`SPS_ADDR_W-1:0] addr_inc;
  logic [`SPS_ADDR_W-1:0] rd_addr;
  logic [`SPS_DATA_W-1:0] rx_word;
  logic [`SPS_DATA_W-1:0] rd_data;
  logic word_end;
  logic resp_now;
  logic load_tx;
  logic wr_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Link sampling and edge detection.

  sps_sync #(.W(3), .RST_VAL(3'h2)) u_link_sync (
    .clk(clk),
    .rst(rst),
    .d({link.sclk, link.cs_n, link.mosi}),
    .q(link_s)
  );

  assign sclk_s = link_s[2];
  assign cs_n_s = link_s[1];
  assign mosi_s = link_s[0];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  always_comb
  begin
    // The idle level is set by the polarity, so a pulse leads away from it.
    lead = cpol ? (sclk_prev_q & ~sclk_s) : (~sclk_prev_q & sclk_s); // [R3]
    trail = cpol ? (~sclk_prev_q & sclk_s) : (sclk_prev_q & ~sclk_s); // [R3]
    sample_edge = cpha ? trail : lead; // [R4] [R5]
    shift_edge = cpha ? lead : trail; // [R4] [R5]
    cs_fall = cs_prev_q & ~cs_n_s; // [R7]
    cmd_byte = {cmd_sh_q, mosi_s};
    cmd_addr = bit_order_swap ? sps_pkg::sps_rev6(cmd_byte[6:1]) : cmd_byte[6:1]; // [R8] [R9]
    addr_inc = (addr_q == `SPS_WRAP_ADDR) ? 6'h00 : addr_q + 6'h01; // [R14]
    rx_word = bit_order_swap ? {mosi_s, rx_sh_q[15:1]} : {rx_sh_q[14:0], mosi_s}; // [R11]
    word_end = sample_edge && (cnt_q == `SPS_WORD_LAST);
    resp_now = !serial_port_disable && // [R22]
      (!match_q[`SPS_MATCH_EN_BIT] || (match_q[4:0] == mgmt_port_address_q)); // [R20] [R21]
    rd_addr = (state_q == sps_pkg::SPS_D_CMD) ? cmd_addr : addr_inc;
    if (rd_addr == `SPS_STATUS_ADDR)
      rd_data = status_q;
    else if (rd_addr == `SPS_MATCH_ADDR)
      rd_data = match_q;
    else
      rd_data = regs_q[rd_addr]; // [R2]
    load_tx = !cs_n_s && sample_edge &&
      (((state_q == sps_pkg::SPS_D_CMD) && (cnt_q == `SPS_CMD_LAST) && cmd_byte[7]) ||
       ((state_q == sps_pkg::SPS_D_TX) && (cnt_q == `SPS_WORD_LAST) && burst_q));
    wr_fire = !cs_n_s && (state_q == sps_pkg::SPS_D_RX) && word_end && !serial_port_disable; // [R12] [R18]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= sps_pkg::SPS_D_IDLE;
      cnt_q <= 5'h00;
      cmd_sh_q <= 7'h00;
      rx_sh_q <= 16'h0000;
      tx_sh_q <= 16'h0000;
      addr_q <= 6'h00;
      burst_q <= 1'b0;
    end
    else if (cs_n_s)
    begin
      state_q <= sps_pkg::SPS_D_IDLE; // [R18]
      cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        sps_pkg::SPS_D_IDLE:
        begin
          if (cs_fall)
          begin
            state_q <= sps_pkg::SPS_D_CMD; // [R7]
            cnt_q <= 5'h00;
          end
        end
        sps_pkg::SPS_D_CMD:
        begin
          if (sample_edge)
          begin
            cmd_sh_q <= cmd_byte[6:0];
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `SPS_CMD_LAST)
            begin
              cnt_q <= 5'h00;
              addr_q <= cmd_addr; // [R8]
              burst_q <= cmd_byte[0]; // [R10]
              state_q <= cmd_byte[7] ? sps_pkg::SPS_D_TX : sps_pkg::SPS_D_RX; // [R10]
              if (cmd_byte[7])
                tx_sh_q <= rd_data; // [R13]
            end
          end
        end
        sps_pkg::SPS_D_RX:
        begin
          if (sample_edge)
          begin
            rx_sh_q <= rx_word;
            cnt_q <= cnt_q + 5'h01;
            if (word_end)
            begin
              cnt_q <= 5'h00;
              if (burst_q)
                addr_q <= addr_inc; // [R14]
              else
                state_q <= sps_pkg::SPS_D_CMD; // [R12]
            end
          end
        end
        sps_pkg::SPS_D_TX:
        begin
          if (shift_edge)
            tx_sh_q <= bit_order_swap ? {1'b0, tx_sh_q[15:1]} : {tx_sh_q[14:0], 1'b0}; // [R11]
          if (sample_edge)
          begin
            cnt_q <= cnt_q + 5'h01;
            if (word_end)
            begin
              cnt_q <= 5'h00;
              if (burst_q)
              begin
                addr_q <= addr_inc; // [R15]
                tx_sh_q <= rd_data; // [R15]
              end
              else
                state_q <= sps_pkg::SPS_D_CMD; // [R13]
            end
          end
        end
        default:
          state_q <= sps_pkg::SPS_D_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data out. The select pin clears it directly, so the line floats without
  // waiting for the synchroniser; the price is a second asynchronous clear.

  always_ff @(posedge clk or posedge rst or posedge link.cs_n)
  begin
    if (rst || link.cs_n)
    begin
      sdo_q <= 1'b1; // [R6]
      sdo_oe_q <= 1'b0; // [R6]
    end
    else if (shift_edge)
    begin
      if ((state_q == sps_pkg::SPS_D_TX) && resp_now && !cs_n_s)
      begin
        sdo_oe_q <= 1'b1; // [R1]
        sdo_q <= bit_order_swap ? tx_sh_q[0] : tx_sh_q[15]; // [R11]
      end
      else
        sdo_oe_q <= 1'b0; // [R1]
    end
  end

  assign link.sdo = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `SPS_NUM_REGS; i++)
        regs_q[i] <= `SPS_REG_RESET;
    end
    else if (wr_fire && resp_now && (addr_q != `SPS_MATCH_ADDR) && (addr_q != `SPS_STATUS_ADDR))
      regs_q[addr_q] <= rx_word; // [R12] [R14]
  end

  // Every device on a shared select whose serial port is not disabled takes the match write, matched or not.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      match_q <= `SPS_MATCH_RESET;
    else if (wr_fire && (addr_q == `SPS_MATCH_ADDR))
      match_q <= rx_word; // [R20] [R21]
  end

  // A read, prefetch included, clears the latched bits; a new event wins.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_q <= 16'h0000;
    else if (load_tx && resp_now && (rd_addr == `SPS_STATUS_ADDR))
      status_q <= status_set; // [R15] [R17]
    else
      status_q <= status_q | status_set;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_strobe_q <= 1'b0;
      wr_addr_q <= 6'h00;
      wr_data_q <= 16'h0000;
    end
    else
    begin
      wr_strobe_q <= wr_fire && (resp_now || (addr_q == `SPS_MATCH_ADDR));
      if (wr_fire)
      begin
        wr_addr_q <= addr_q;
        wr_data_q <= rx_word;
      end
    end
  end

  // Straps are held only while reset is high, so this capture has no reset.
  always_ff @(posedge clk)
  begin
    strap_meta_q <= {rxd_hi, rx_er};
    if (rst)
      mgmt_port_address_q <= strap_meta_q; // [R23]
  end

endmodule // sps_device

// ==== core/sps_host.sv ====
`include "sps_params.svh"

module sps_host (
  // Serial link to the device
  sps_if.host link,
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q
);

  sps_pkg::sps_host_state_type state_q;
  logic [2:0] ctrl_q;
  logic [7:0] cmd_q;
  logic [15:0] txdata_q;
  logic [15:0] rxdata_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [15:0] load_val;
  logic [15:0] rx_full;
  logic [7:0] div_q;
  logic [4:0] cnt_q;
  logic [4:0] last_bit;
  logic tick;
  logic cap_q;
  logic lead_next_q;
  logic is_cmd_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic miso_s;
  logic hpol;
  logic hpha;
  logic hswap;

  sps_sync #(.W(1), .RST_VAL(1'b1)) u_miso_sync (
    .clk(clk),
    .rst(rst),
    .d(link.miso),
    .q(miso_s)
  );

  always_comb
  begin
    hpol = ctrl_q[`SPS_CTRL_CPOL];
    hpha = ctrl_q[`SPS_CTRL_CPHA];
    hswap = ctrl_q[`SPS_CTRL_SWAP];
    tick = (div_q == 8'(`SPS_SCLK_HALF_CYC - 1));
    last_bit = is_cmd_q ? `SPS_CMD_LAST : `SPS_WORD_LAST;
    rx_full = cap_q ? {rx_q[14:0], miso_s} : rx_q;
    if (is_cmd_q)
      load_val = {cmd_q[`SPS_CMD_READ], // [R8] [R9]
        (hswap ? sps_pkg::sps_rev6(cmd_q[5:0]) : cmd_q[5:0]), cmd_q[`SPS_CMD_BURST], 8'h00};
    else
      load_val = hswap ? sps_pkg::sps_rev16(txdata_q) : txdata_q; // [R11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: one tick per half period of the serial clock.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_q <= 8'h00;
    else if ((state_q == sps_pkg::SPS_H_IDLE) || (state_q == sps_pkg::SPS_H_HOLD) || tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer. Read bits are taken one half period after the edge the
  // device samples on, which covers the device's sampling lag and the miso
  // synchroniser.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= sps_pkg::SPS_H_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      rxdata_q <= 16'h0000;
      cnt_q <= 5'h00;
      cap_q <= 1'b0;
      lead_next_q <= 1'b1;
      is_cmd_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        sps_pkg::SPS_H_IDLE:
        begin
          sclk_q <= hpol; // [R3]
          if (reg_wr && (reg_addr == `SPS_H_CMD))
          begin
            cs_n_q <= 1'b0; // [R7]
            is_cmd_q <= 1'b1;
            state_q <= sps_pkg::SPS_H_START;
          end
        end
        sps_pkg::SPS_H_START:
        begin
          if (tick)
          begin
            cnt_q <= 5'h00;
            lead_next_q <= 1'b1;
            tx_q <= load_val;
            if (!hpha)
            begin
              mosi_q <= load_val[15]; // [R4]
              tx_q <= {load_val[14:0], 1'b0};
            end
            state_q <= sps_pkg::SPS_H_SHIFT;
          end
        end
        sps_pkg::SPS_H_SHIFT:
        begin
          if (tick)
          begin
            if (cap_q)
              rx_q <= rx_full;
            cap_q <= 1'b0;
            if (lead_next_q)
            begin
              sclk_q <= ~hpol; // [R3]
              lead_next_q <= 1'b0;
              if (hpha)
              begin
                mosi_q <= tx_q[15]; // [R5]
                tx_q <= {tx_q[14:0], 1'b0};
              end
              else
                cap_q <= 1'b1; // [R4]
            end
            else
            begin
              sclk_q <= hpol;
              lead_next_q <= 1'b1;
              cnt_q <= cnt_q + 5'h01;
              if (hpha)
                cap_q <= 1'b1; // [R5]
              else if (cnt_q != last_bit)
              begin
                mosi_q <= tx_q[15]; // [R4]
                tx_q <= {tx_q[14:0], 1'b0};
              end
              if (cnt_q == last_bit)
                state_q <= sps_pkg::SPS_H_TAIL;
            end
          end
        end
        sps_pkg::SPS_H_TAIL:
        begin
          if (tick)
          begin
            cap_q <= 1'b0;
            rx_q <= rx_full;
            if (is_cmd_q)
            begin
              is_cmd_q <= 1'b0;
              state_q <= sps_pkg::SPS_H_START;
            end
            else
            begin
              rxdata_q <= hswap ? sps_pkg::sps_rev16(rx_full) : rx_full; // [R11]
              state_q <= cmd_q[`SPS_CMD_BURST] ? sps_pkg::SPS_H_HOLD : sps_pkg::SPS_H_FIN;
            end
          end
        end
        sps_pkg::SPS_H_HOLD:
        begin
          if (reg_wr && (reg_addr == `SPS_H_STAT))
            state_q <= reg_wdata[0] ? sps_pkg::SPS_H_START : sps_pkg::SPS_H_FIN;
        end
        sps_pkg::SPS_H_FIN:
        begin
          // Select stays high for a full half period before a new command.
          if (tick)
          begin
            if (cs_n_q)
              state_q <= sps_pkg::SPS_H_IDLE;
            cs_n_q <= 1'b1; // [R16] [R19]
          end
        end
        default:
          state_q <= sps_pkg::SPS_H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `SPS_CTRL_RESET;
      txdata_q <= 16'h0000;
      cmd_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SPS_H_CTRL)
        ctrl_q <= reg_wdata[2:0];
      if (reg_addr == `SPS_H_DATA)
        txdata_q <= reg_wdata;
      if ((reg_addr == `SPS_H_CMD) && (state_q == sps_pkg::SPS_H_IDLE))
        cmd_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SPS_H_CTRL: reg_rdata_q <= {13'h0000, ctrl_q};
        `SPS_H_CMD: reg_rdata_q <= {8'h00, cmd_q};
        `SPS_H_DATA: reg_rdata_q <= rxdata_q;
        `SPS_H_STAT: reg_rdata_q <= {14'h0000, (state_q == sps_pkg::SPS_H_HOLD),
          (state_q != sps_pkg::SPS_H_IDLE)};
        default: reg_rdata_q <= 16'h0000;
      endcase
    end
  end

endmodule // sps_host

// ==== core/sps_if.sv ====
interface sps_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic sdo;
  logic sdo_oe;
  logic miso;

  // A floating data-out line is seen as high through its pull-up.
  assign miso = sdo_oe ? sdo : 1'b1;

  modport device (input sclk, input cs_n, input mosi, output sdo, output sdo_oe);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ==== core/sps_params.svh ====
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
// Summary of operation
// R1 - Data out floats unless shifting read data
// R2 - Six-bit address space, sixteen-bit registers
// R3 - Polarity setting picks clock idle level
// R4 - Phase zero: sample leading, change trailing
// R5 - Phase one: sample trailing, change leading
// R6 - Select release floats output, aborts, asynchronously
// R7 - Select falling edge starts an access sequence
// R8 - Command: direction, address high first, burst
// R9 - Swap sends command address low bit first
// R10 - Direction one reads; burst one bursts
// R11 - Data words MSB first, LSB when swapped
// R12 - Single write stores after last bit
// R13 - Single read returns register, then command
// R14 - Burst write stores, increments, wraps at 1Fh
// R15 - Burst read increments and prefetches next
// R16 - Master ends bursts by raising select
// R17 - Master avoids ending before latched status
// R18 - Early release resets port, drops partial word
// R19 - Shared wire: master releases line, select
// R20 - Match enabled: respond only on address match
// R21 - Match disabled: every device responds
// R22 - Port active at reset; disable blocks it
// R23 - Management address captured from straps during reset

`define SPS_ADDR_W 6
`define SPS_DATA_W 16
`define SPS_NUM_REGS 64
`define SPS_CMD_LAST 5'h07
`define SPS_WORD_LAST 5'h0f
`define SPS_WRAP_ADDR 6'h1f
`define SPS_STATUS_ADDR 6'h3d
`define SPS_MATCH_ADDR 6'h3e
`define SPS_MATCH_EN_BIT 8
`define SPS_REG_RESET 16'h0000
`define SPS_MATCH_RESET 16'h0000
// Host register map.
`define SPS_H_CTRL 2'h0
`define SPS_H_CMD 2'h1
`define SPS_H_DATA 2'h2
`define SPS_H_STAT 2'h3
`define SPS_CTRL_CPOL 0
`define SPS_CTRL_CPHA 1
`define SPS_CTRL_SWAP 2
`define SPS_CMD_READ 6
`define SPS_CMD_BURST 7
`define SPS_CTRL_RESET 3'h0
// Timing.
`define SPS_CLK_PERIOD_NS 50
`define SPS_SCLK_HALF_NS 200
`define SPS_SCLK_HALF_CYC ((`SPS_SCLK_HALF_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS)
`endif

// ==== core/sps_pkg.sv ====
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_D_IDLE = 2'h0,
    SPS_D_CMD = 2'h1,
    SPS_D_RX = 2'h3,
    SPS_D_TX = 2'h2
  } sps_dev_state_type;

  typedef enum logic [2:0] {
    SPS_H_IDLE = 3'h0,
    SPS_H_START = 3'h1,
    SPS_H_SHIFT = 3'h3,
    SPS_H_TAIL = 3'h2,
    SPS_H_HOLD = 3'h6,
    SPS_H_FIN = 3'h7
  } sps_host_state_type;

  function automatic logic [5:0] sps_rev6(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++)
      r[i] = v[5 - i];
    return r;
  endfunction

  function automatic logic [15:0] sps_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15 - i];
    return r;
  endfunction

endpackage

// ==== core/sps_sync.sv ====
module sps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sps_sync

// ==== tb/spi_slave_register_port_tb_top.sv ====
`include "sps_params.svh"

`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) \
    begin \
      errors++; \
      $display("BAD %s exp %h got %h", nm, ex, gt); \
    end \
  end

module spi_slave_register_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic swap = 1'b0;
  logic dis = 1'b0;
  logic [3:0] rxd_hi;
  logic rx_er;
  logic [15:0] status_set = 16'h0000;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_q;
  logic wr_strobe_q;
  logic [5:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic [4:0] mgmt_port_address_q;
  logic [4:0] mgmt;
  int errors = 0;
  int cmp_count = 0;
  int mem [64];
  logic [21:0] exp_q [$];

  sps_if link ();
  sps_device i_sps_device (.link(link), .clk(clk), .rst(rst), .cpol(cpol), .cpha(cpha), .bit_order_swap(swap),
    .serial_port_disable(dis), .rxd_hi(rxd_hi), .rx_er(rx_er), .status_set(status_set),
    .wr_strobe_q(wr_strobe_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .mgmt_port_address_q(mgmt_port_address_q));
  sps_host i_sps_host (.link(link), .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  sps_assertions i_sps_assertions (.clk(clk), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .sdo(link.sdo), .sdo_oe(link.sdo_oe), .miso(link.miso));

  always #25 clk = ~clk;

  ////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every stored word must be one the model expects, in order.
  always @(posedge clk)
  begin
    logic [21:0] e;
    if (!rst && wr_strobe_q === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 22'h3fffff;
      `CHK("store", e, {wr_addr_q, wr_data_q})
    end
  end

  ////////////////////////////////////////
  function automatic logic [5:0] nxt(input logic [5:0] p);
    return (p == `SPS_WRAP_ADDR) ? 6'h00 : p + 6'h01;
  endfunction

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata_q;
  endtask

  task automatic setmode(input logic [2:0] m);
    @(posedge clk);
    {swap, cpha, cpol} <= m;
    wr(`SPS_H_CTRL, {13'h0000, m});
  endtask

  // One access of n words; live says whether this device is expected to take part.
  task automatic xfer(input bit rd_op, input bit burst, input logic [5:0] a, input int n, input bit live,
                      input logic [15:0] d0);
    logic [15:0] w [8];
    logic [15:0] s;
    logic [15:0] v;
    logic [5:0] p;
    int got;
    int i;
    got = 0;
    p = a;
    w[0] = d0;
    for (i = 1; i < 8; i++)
      w[i] = 16'($urandom);
    for (i = 0; i < n; i++)
    begin
      if (!rd_op && live)
      begin
        exp_q.push_back({p, w[i]});
        mem[p] = w[i];
      end
      p = nxt(p);
    end
    p = a;
    wr(`SPS_H_DATA, w[0]);
    wr(`SPS_H_CMD, {8'h00, burst, rd_op, a});
    for (i = 0; i < 4000; i++)
    begin
      rd(`SPS_H_STAT, s);
      if (s[1] || (!s[0] && got < n))
      begin
        if (rd_op)
        begin
          rd(`SPS_H_DATA, v);
          `CHK("read word", (live ? 16'(mem[p]) : 16'hffff), v)
        end
        got++;
        p = nxt(p);
        if (s[1] && got < n)
          wr(`SPS_H_DATA, w[got]);
        if (s[1])
          wr(`SPS_H_STAT, {15'h0000, got < n});
      end
      if (!s[0])
        break;
    end
    if (i == 4000)
    begin
      errors++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////
  initial
  begin
    int m;
    logic [5:0] a;
    void'($urandom(34));
    rxd_hi = 4'($urandom);
    rx_er = 1'($urandom);
    mgmt = {rxd_hi, rx_er};
    for (m = 0; m < 64; m++)
      mem[m] = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    `CHK("mgmt address", mgmt, mgmt_port_address_q)
    xfer(1'b1, 1'b0, 6'h3c, 1, 1'b1, 16'h0000);
    // Every polarity, phase and bit order, each with a write and its read-back.
    for (m = 0; m < 8; m++)
    begin
      setmode(3'(m));
      a = 6'($urandom % 61);
      xfer(1'b0, 1'b0, a, 1, 1'b1, 16'($urandom));
      xfer(1'b1, 1'b0, a, 1, 1'b1, 16'h0000);
    end
    xfer(1'b0, 1'b1, 6'h1e, 3, 1'b1, 16'($urandom));
    xfer(1'b1, 1'b1, 6'h1e, 3, 1'b1, 16'h0000);
    // A latched event is read once, then the read itself has cleared it.
    @(posedge clk);
    status_set <= 16'h0081;
    @(posedge clk);
    status_set <= 16'h0000;
    mem[`SPS_STATUS_ADDR] = 32'h0081;
    xfer(1'b1, 1'b0, `SPS_STATUS_ADDR, 1, 1'b1, 16'h0000);
    mem[`SPS_STATUS_ADDR] = 0;
    xfer(1'b1, 1'b0, `SPS_STATUS_ADDR, 1, 1'b1, 16'h0000);
    a = 6'h05;
    xfer(1'b0, 1'b0, `SPS_MATCH_ADDR, 1, 1'b1, {7'h00, 1'b1, 3'h0, mgmt ^ 5'h01});
    xfer(1'b0, 1'b0, a, 1, 1'b0, 16'h1234);
    xfer(1'b1, 1'b0, a, 1, 1'b0, 16'h0000);
    xfer(1'b0, 1'b0, `SPS_MATCH_ADDR, 1, 1'b1, {7'h00, 1'b1, 3'h0, mgmt});
    xfer(1'b0, 1'b0, a, 1, 1'b1, 16'($urandom));
    xfer(1'b1, 1'b0, a, 1, 1'b1, 16'h0000);
    xfer(1'b0, 1'b0, `SPS_MATCH_ADDR, 1, 1'b1, 16'h0000);
    xfer(1'b0, 1'b0, a, 1, 1'b1, 16'($urandom));
    @(posedge clk);
    dis <= 1'b1;
    xfer(1'b0, 1'b0, a, 1, 1'b0, 16'h5a5a);
    xfer(1'b1, 1'b0, a, 1, 1'b0, 16'h0000);
    @(posedge clk);
    dis <= 1'b0;
    xfer(1'b1, 1'b0, a, 1, 1'b1, 16'h0000);
    repeat (8) @(posedge clk);
    `CHK("pending stores", 0, exp_q.size())
    print_verdict();
  end
endmodule // spi_slave_register_port_tb_top

// ==== tb/sps_assertions.sv ====
module sps_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic miso
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  // Counts serial clock edges since select fell, so the command's sixteen edges can be told apart from data.
  logic sclk_q;
  logic [9:0] edges_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b0;
      edges_q <= 10'h000;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
        edges_q <= 10'h000;
      else if (sclk != sclk_q)
        edges_q <= edges_q + 10'h001;
    end
  end

  ////////////////////////////////////////
  sequence s_word_out;
    (sdo_oe || cs_n) [*8];
  endsequence

  sequence s_start_idle;
    $stable(sclk) [*3];
  endsequence

  a_oe_off_deselect: assert property (cs_n |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_oe_after_cmd: assert property (sdo_oe |-> edges_q >= 10'h010)
    else $error("data out driven during the command byte");
  a_oe_needs_select: assert property ($rose(sdo_oe) |-> $past(cs_n, 60) == 1'b0)
    else $error("data out driven too soon after select");
  a_oe_word_len: assert property ($rose(sdo_oe) |-> s_word_out)
    else $error("read word cut short");
  a_miso_float: assert property (cs_n |-> sdo && miso)
    else $error("data out not idle high while deselected");
  a_start_idle: assert property ($fell(cs_n) |-> s_start_idle)
    else $error("serial clock moved at frame start");
  a_select_min: assert property ($fell(cs_n) |=> !cs_n [*8])
    else $error("select pulse too short");
  a_frame_even: assert property ($rose(cs_n) |-> !edges_q[0])
    else $error("frame ended with clock away from idle");
endmodule // sps_assertions
